// [design/irq_ctrl_pkg.sv]
// Shared constants and types for the vectored interrupt controller
package irq_ctrl_pkg;
  localparam int NUM_SRC = 29;
  localparam int NUM_VEC = 10;
  localparam int VEC_IDX_W = 4;
  localparam int VEC_ADDR_W = 20;

  // Priority levels, ordered highest above high above low
  localparam logic [1:0] LVL_NONE = 2'h0;
  localparam logic [1:0] LVL_LOW = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [1:0] LVL_TOP = 2'h3;

  // Vector addresses by vector index
  localparam logic [VEC_ADDR_W-1:0] VEC_ADDR [NUM_VEC] = '{
    20'h00003, 20'h0000B, 20'h00013, 20'h0001B, 20'h00023,
    20'h0002B, 20'h00033, 20'h0003B, 20'h00043, 20'h0004B
  };

  // Source bit positions
  localparam int SRC_EXT_A = 0;
  localparam int SRC_EXT_B = 1;
  localparam int SRC_EXT_C = 2;
  localparam int SRC_TMR0_LO = 3;
  localparam int SRC_EXT_E = 4;
  localparam int SRC_EXT_D = 5;
  localparam int SRC_EXT_F = 6;
  localparam int SRC_BASE_TMR_A = 7;
  localparam int SRC_BASE_TMR_B = 8;
  localparam int SRC_TMR0_HI = 9;
  localparam int SRC_EXT_G = 10;
  localparam int SRC_TMR1_LO = 11;
  localparam int SRC_TMR1_HI = 12;
  localparam int SRC_EXT_H = 13;
  localparam int SRC_SYNC_A = 14;
  localparam int SRC_UART_A_RX = 15;
  localparam int SRC_UART_B_RX = 16;
  localparam int SRC_SER_B = 17;
  localparam int SRC_SYNC_C = 18;
  localparam int SRC_UART_A_TX = 19;
  localparam int SRC_UART_B_TX = 20;
  localparam int SRC_ADC = 21;
  localparam int SRC_TMR6 = 22;
  localparam int SRC_TMR7 = 23;
  localparam int SRC_PWM_C = 24;
  localparam int SRC_PWM_D = 25;
  localparam int SRC_PORT0 = 26;
  localparam int SRC_TMR4 = 27;
  localparam int SRC_TMR5 = 28;
  // Pwm a and b reach bits 26..28 merged outside this block

  // Vector index of each source
  localparam logic [VEC_IDX_W-1:0] SRC_VEC [NUM_SRC] = '{
    4'h0, 4'h1, 4'h2, 4'h2, 4'h2, 4'h3, 4'h3, 4'h3, 4'h3, 4'h4,
    4'h4, 4'h5, 4'h5, 4'h5, 4'h6, 4'h6, 4'h6, 4'h7, 4'h7, 4'h7,
    4'h7, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h9, 4'h9, 4'h9
  };

  // Request to the core
  typedef struct packed {
    logic valid;
    logic [VEC_IDX_W-1:0] idx;
    logic [VEC_ADDR_W-1:0] addr;
    logic [1:0] level;
  } irq_req_s;
endpackage : irq_ctrl_pkg

// [design/irq_sync.sv]
// Two-flop synchroniser bank for pin-side request inputs
`timescale 1ns/1ps
module irq_sync #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  always_comb
  begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;
endmodule : irq_sync

// [design/irq_arbiter.sv]
// Level and vector-address arbitration over pending vectors
`timescale 1ns/1ps
module irq_arbiter #(
  parameter int NUM_VEC = 10
) (
  input wire logic [NUM_VEC-1:0] vec_req,
  input wire logic [2*NUM_VEC-1:0] vec_level,
  input wire logic [1:0] cur_level,
  output logic win_valid,
  output logic [3:0] win_idx,
  output logic [1:0] win_level
);
  always_comb
  begin
    win_valid = 1'b0;
    win_idx = 4'h0;
    win_level = irq_ctrl_pkg::LVL_NONE;
    // Ascending scan, strict compare keeps smallest vector on ties
    for (int i = 0; i < NUM_VEC; i++)
    begin
      if (vec_req[i] && (vec_level[2*i +: 2] > cur_level)
          && (!win_valid || (vec_level[2*i +: 2] > win_level)))
      begin
        win_valid = 1'b1;
        win_idx = 4'(i);
        win_level = vec_level[2*i +: 2];
      end
    end
  end
endmodule : irq_arbiter

// [design/irq_ctrl.sv]
// Multilevel vectored interrupt controller top
// Operation
// - Three levels: low, high, highest; each vector serviced at its own level.
// - While servicing, requests at equal or lower level are refused.
// - Several pending vectors: highest level wins.
// - Same level: smallest vector address wins.
// - Twenty-nine sources merged onto ten vectors.
// - Pin a to 00003H, pin b to 0000BH; only these may be highest.
// - 0001BH: external d, f and both base timers; high or low.
// - 00033H: sync serial a, both UART receives; high or low.
// - 0003BH: serial b, sync serial c, both UART transmits; high or low.
// - 00043H: converter, timers six, seven, pwm c, d; high or low.
// - 0004BH: port zero, timers four, five, pwm a, b; high or low.
// - 00013H, 00023H, 0002BH carry their listed sources; high or low.
`timescale 1ns/1ps
module irq_ctrl #(
  parameter int NUM_PIN = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [NUM_PIN-1:0] ext_irq_pin,
  input wire logic [irq_ctrl_pkg::NUM_SRC-1:0] periph_irq,
  input wire logic [irq_ctrl_pkg::NUM_SRC-1:0] src_enable,
  input wire logic [irq_ctrl_pkg::NUM_SRC-1:0] src_clear,
  input wire logic [irq_ctrl_pkg::NUM_VEC-1:0] level_hi_sel,
  input wire logic [1:0] top_level_sel,
  input wire logic core_accept,
  input wire logic core_return,
  output irq_ctrl_pkg::irq_req_s irq_req,
  output logic [irq_ctrl_pkg::NUM_SRC-1:0] src_pending,
  output logic [1:0] service_level
);
  localparam int NS = irq_ctrl_pkg::NUM_SRC;
  localparam int NV = irq_ctrl_pkg::NUM_VEC;
  localparam int DEPTH = 3;

  logic [NUM_PIN-1:0] pin_sync;
  logic [NUM_PIN-1:0] pin_prev_ff;
  logic [NUM_PIN-1:0] pin_rise;
  logic [NS-1:0] src_event;
  logic [NS-1:0] pend_ff;
  logic [NS-1:0] nxt_pend;
  logic [NV-1:0] vec_req;
  logic [2*NV-1:0] vec_level;
  logic win_valid;
  logic [3:0] win_idx;
  logic [1:0] win_level;
  logic [1:0] stack_ff [DEPTH];
  logic [1:0] nxt_stack [DEPTH];
  logic [1:0] sp_ff;
  logic [1:0] nxt_sp;
  irq_ctrl_pkg::irq_req_s req_ff;
  irq_ctrl_pkg::irq_req_s nxt_req;

  irq_sync #(
    .WIDTH(NUM_PIN)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(ext_irq_pin),
    .sync_out(pin_sync)
  );

  // Level assignable to a vector from its select bits
  function automatic logic [1:0] vec_lvl(input int v, input logic hi, input logic top);
    if (v < 2 && top)
      vec_lvl = irq_ctrl_pkg::LVL_TOP;
    else if (v >= 2 && hi)
      vec_lvl = irq_ctrl_pkg::LVL_HIGH;
    else
      vec_lvl = irq_ctrl_pkg::LVL_LOW;
  endfunction : vec_lvl

  assign pin_rise = pin_sync & ~pin_prev_ff;

  // Pin edges land on external sources, others come from peripherals
  always_comb
  begin
    src_event = periph_irq;
    src_event[irq_ctrl_pkg::SRC_EXT_A] = pin_rise[0] | periph_irq[irq_ctrl_pkg::SRC_EXT_A];
    src_event[irq_ctrl_pkg::SRC_EXT_B] = pin_rise[1] | periph_irq[irq_ctrl_pkg::SRC_EXT_B];
    src_event[irq_ctrl_pkg::SRC_EXT_C] = pin_rise[2] | periph_irq[irq_ctrl_pkg::SRC_EXT_C];
    src_event[irq_ctrl_pkg::SRC_EXT_D] = pin_rise[3] | periph_irq[irq_ctrl_pkg::SRC_EXT_D];
    src_event[irq_ctrl_pkg::SRC_EXT_E] = pin_rise[4] | periph_irq[irq_ctrl_pkg::SRC_EXT_E];
    src_event[irq_ctrl_pkg::SRC_EXT_F] = pin_rise[5] | periph_irq[irq_ctrl_pkg::SRC_EXT_F];
    src_event[irq_ctrl_pkg::SRC_EXT_G] = pin_rise[6] | periph_irq[irq_ctrl_pkg::SRC_EXT_G];
    src_event[irq_ctrl_pkg::SRC_EXT_H] = pin_rise[7] | periph_irq[irq_ctrl_pkg::SRC_EXT_H];
  end

  // Sticky flags, set wins over clear
  always_comb
  begin
    nxt_pend = (pend_ff & ~src_clear) | src_event;
  end

  // Merge enabled pending sources per vector
  always_comb
  begin
    vec_req = '0;
    for (int s = 0; s < NS; s++)
    begin
      if (pend_ff[s] && src_enable[s])
        vec_req[irq_ctrl_pkg::SRC_VEC[s]] = 1'b1;
    end
  end

  genvar gv;
  generate
    for (gv = 0; gv < NV; gv++)
    begin : g_lvl
      assign vec_level[2*gv +: 2] =
        vec_lvl(gv, level_hi_sel[gv], (gv < 2) ? top_level_sel[gv % 2] : 1'b0);
    end
  endgenerate

  irq_arbiter #(
    .NUM_VEC(NV)
  ) u_arb (
    .vec_req(vec_req),
    .vec_level(vec_level),
    .cur_level((sp_ff == 2'h0) ? irq_ctrl_pkg::LVL_NONE : stack_ff[sp_ff - 2'h1]),
    .win_valid(win_valid),
    .win_idx(win_idx),
    .win_level(win_level)
  );

  // Request offer and nesting stack
  always_comb
  begin
    nxt_req = req_ff;
    nxt_sp = sp_ff;
    for (int i = 0; i < DEPTH; i++)
      nxt_stack[i] = stack_ff[i];
    if (core_accept && req_ff.valid && sp_ff < 2'(DEPTH))
    begin
      nxt_stack[sp_ff] = req_ff.level;
      nxt_sp = sp_ff + 2'h1;
      nxt_req.valid = 1'b0;
    end
    else if (core_return && sp_ff != 2'h0)
    begin
      nxt_sp = sp_ff - 2'h1;
      nxt_req.valid = 1'b0;
    end
    else
    begin
      nxt_req.valid = win_valid;
      nxt_req.idx = win_idx;
      nxt_req.addr = irq_ctrl_pkg::VEC_ADDR[win_idx];
      nxt_req.level = win_level;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_ff <= '0;
      pin_prev_ff <= '0;
      sp_ff <= 2'h0;
      req_ff <= '0;
      for (int i = 0; i < DEPTH; i++)
        stack_ff[i] <= irq_ctrl_pkg::LVL_NONE;
    end
    else
    begin
      pend_ff <= nxt_pend;
      pin_prev_ff <= pin_sync;
      sp_ff <= nxt_sp;
      req_ff <= nxt_req;
      for (int i = 0; i < DEPTH; i++)
        stack_ff[i] <= nxt_stack[i];
    end
  end

  logic [1:0] svc_ff;
  logic [1:0] nxt_svc;
  always_comb
  begin
    nxt_svc = (nxt_sp == 2'h0) ? irq_ctrl_pkg::LVL_NONE : nxt_stack[nxt_sp - 2'h1];
  end
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      svc_ff <= irq_ctrl_pkg::LVL_NONE;
    else
      svc_ff <= nxt_svc;
  end

  assign irq_req = req_ff;
  assign src_pending = pend_ff;
  assign service_level = svc_ff;
endmodule : irq_ctrl

// [bench/irq_ctrl_asserts.sv]
// Port assertions and covers for the interrupt controller
`timescale 1ns/1ps
module irq_ctrl_asserts (
  input logic sys_clk,
  input logic rst_n,
  input logic [28:0] periph_irq,
  input logic [28:0] src_enable,
  input logic [28:0] src_clear,
  input logic core_accept,
  input irq_ctrl_pkg::irq_req_s irq_req,
  input logic [28:0] src_pending,
  input logic [1:0] service_level
);
  // Pin-fed flags set late, so clears are judged off them
  localparam logic [28:0] PIN_SRC = 29'h0002477;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_ABOVE: assert property (irq_req.valid |-> irq_req.level > service_level)
    else $error("offer at or below service level");
  AST_ADDR: assert property (
    irq_req.valid |-> irq_req.addr == irq_ctrl_pkg::VEC_ADDR[irq_req.idx])
    else $error("vector address wrong");
  AST_TOP: assert property (
    irq_req.valid && irq_req.level == 2'h3 |-> irq_req.idx < 4'h2)
    else $error("highest level off pins a b");
  AST_SET: assert property (
    periph_irq != 29'h0 |=> (src_pending & $past(periph_irq)) == $past(periph_irq))
    else $error("flag not set");
  AST_CLR: assert property (
    src_clear != 29'h0 |=> (src_pending & $past(src_clear & ~periph_irq & ~PIN_SRC)) == 29'h0)
    else $error("flag not cleared");
  AST_CAUSE: assert property (irq_req.valid |-> $past(|(src_pending & src_enable)))
    else $error("offer without enabled flag");
  AST_PUSH: assert property (
    core_accept && irq_req.valid |=> service_level == $past(irq_req.level))
    else $error("service level not pushed");
  AST_DROP: assert property (core_accept && irq_req.valid |=> !irq_req.valid)
    else $error("offer stands after accept");
  COV_TOP: cover property (irq_req.valid && irq_req.level == 2'h3);
  COV_ACC: cover property (core_accept && irq_req.valid);
  COV_NEST: cover property (irq_req.valid && service_level != 2'h0);
endmodule : irq_ctrl_asserts

bind irq_ctrl irq_ctrl_asserts chk (.sys_clk, .rst_n, .periph_irq, .src_enable, .src_clear,
  .core_accept, .irq_req, .src_pending, .service_level);

// [bench/core_model.sv]
// Core partner: accepts offers and ends service on command
`timescale 1ns/1ps
module core_model (
  input logic sys_clk,
  input logic rst_n,
  input irq_ctrl_pkg::irq_req_s irq_req,
  input logic take_en,
  input logic end_en,
  output logic core_accept,
  output logic core_return
);
  always @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      {core_accept, core_return} <= 2'h0;
    else
    begin
      // One-cycle accept, only while an offer stands
      core_accept <= #1 take_en & irq_req.valid & ~core_accept;
      core_return <= #1 end_en & ~core_return;
    end
endmodule : core_model

// [bench/testbench.sv]
// Random and corner-case bench for the interrupt controller
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 1'b0, rst_n = 1'b0, take_en = 1'b0, end_en = 1'b0;
  logic [7:0] ext_irq_pin = 8'h00;
  logic [28:0] periph_irq = 29'h0, src_enable = 29'h0, src_clear = 29'h0, src_pending, p;
  logic [9:0] level_hi_sel = 10'h000;
  logic [1:0] top_level_sel = 2'h0, service_level;
  logic core_accept, core_return;
  irq_ctrl_pkg::irq_req_s irq_req, e;
  int err_count = 0, compares = 0;
  always #4 sys_clk = ~sys_clk;
  irq_ctrl uut (.sys_clk, .rst_n, .ext_irq_pin, .periph_irq, .src_enable, .src_clear,
    .level_hi_sel, .top_level_sel, .core_accept, .core_return, .irq_req, .src_pending,
    .service_level);
  core_model partner (.sys_clk, .rst_n, .irq_req, .take_en, .end_en, .core_accept,
    .core_return);
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    compares++;
    if (seen !== ex)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk
  task automatic stop_test;
    if (err_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  // Sources descend, so ties fall to the smaller vector
  function automatic irq_ctrl_pkg::irq_req_s win(input logic [1:0] cur);
    irq_ctrl_pkg::irq_req_s w;
    logic [1:0] lv;
    logic [3:0] v;
    w = 27'h0;
    for (int s = 28; s >= 0; s--)
    begin
      v = irq_ctrl_pkg::SRC_VEC[s];
      lv = v < 4'h2 ? {top_level_sel[v], 1'b1} : {level_hi_sel[v], ~level_hi_sel[v]};
      if (p[s] && src_enable[s] && lv > cur && lv >= w.level)
        w = {1'b1, v, irq_ctrl_pkg::VEC_ADDR[v], lv};
    end
    return w;
  endfunction : win
  // Flag positions set by a rising edge on each external pin
  function automatic logic [28:0] pin_map(input logic [7:0] pins);
    pin_map = 29'h0;
    pin_map[irq_ctrl_pkg::SRC_EXT_A] = pins[0];
    pin_map[irq_ctrl_pkg::SRC_EXT_B] = pins[1];
    pin_map[irq_ctrl_pkg::SRC_EXT_C] = pins[2];
    pin_map[irq_ctrl_pkg::SRC_EXT_D] = pins[3];
    pin_map[irq_ctrl_pkg::SRC_EXT_E] = pins[4];
    pin_map[irq_ctrl_pkg::SRC_EXT_F] = pins[5];
    pin_map[irq_ctrl_pkg::SRC_EXT_G] = pins[6];
    pin_map[irq_ctrl_pkg::SRC_EXT_H] = pins[7];
  endfunction : pin_map
  task automatic offer(input logic [1:0] cur);
    e = win(cur);
    if (e.valid)
      chk("irq_req", 32'(irq_req), 32'(e));
    else
      chk("valid", 32'(irq_req.valid), 32'h0);
  endtask : offer
  initial
  begin
    #200000 err_count++;
    stop_test();
  end
  initial
  begin
    void'($urandom(36));
    tick(6);
    rst_n = 1'b1;
    for (int i = 0; i < 150; i++)
    begin
      src_clear = 29'h1FFFFFFF;
      tick(2);
      src_clear = 29'h0;
      src_enable = (i < 2) ? 29'h1FFFFFFF : 29'($urandom());
      level_hi_sel = (i == 1) ? 10'h3FF : 10'($urandom());
      top_level_sel = (i < 2) ? 2'h0 : 2'($urandom());
      p = (i < 2) ? 29'h1FFFFFFF : 29'($urandom() & $urandom());
      periph_irq = p;
      tick(1);
      periph_irq = 29'h0;
      tick(1);
      chk("src_pending", 32'(src_pending), 32'(p));
      offer(2'h0);
      if (e.valid)
      begin
        take_en = 1'b1;
        for (int k = 0; k < 8 && service_level == 2'h0; k++)
          tick(1);
        take_en = 1'b0;
        chk("service_level", 32'(service_level), 32'(e.level));
        for (int s = 0; s < 29; s++)
          p[s] = p[s] && irq_ctrl_pkg::SRC_VEC[s] != e.idx;
        src_clear = ~p;
        tick(1);
        src_clear = 29'h0;
        tick(2);
        offer(e.level);
        end_en = 1'b1;
        for (int k = 0; k < 8 && service_level != 2'h0; k++)
          tick(1);
        end_en = 1'b0;
        chk("service_idle", 32'(service_level), 32'h0);
      end
    end
    // Pin path: all pins at once, then random pins
    for (int j = 0; j < 4; j++)
    begin
      ext_irq_pin = 8'h00;
      src_clear = 29'h1FFFFFFF;
      tick(3);
      src_clear = 29'h0;
      ext_irq_pin = (j == 0) ? 8'hFF : 8'($urandom());
      tick(4);
      chk("pin_pending", 32'(src_pending), 32'(pin_map(ext_irq_pin)));
    end
    stop_test();
  end
endmodule : testbench
